// >>> shift_register_pkg.sv
// Shared constants for the four-stage universal shift register
package shift_register_pkg;
    localparam int STAGE_COUNT = 4;
    localparam int SNAPSHOT_DEPTH = 16;
    localparam logic [3:0] STAGES_CLEARED = 4'h0;
    localparam logic SNAP_IDLE = 1'h0;
    localparam logic DROP_NONE = 1'h0;
    typedef enum logic {MODE_LOAD, MODE_SHIFT} mode_t;
    typedef enum logic [1:0] {
        JK_CLEAR,
        JK_HOLD,
        JK_TOGGLE,
        JK_SET
    } jk_action_t;
endpackage

// >>> stream_if.sv
// Valid/ready stream carrying register snapshots
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 4);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// >>> snapshot_fifo.sv
// Snapshot FIFO with registered flags
`timescale 1ns/1ps
module snapshot_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    stream_if.sink push,
    stream_if.source pop
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("snapshot_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic do_push;
    logic do_pop;

    assign do_push = push.valid && push.ready;
    assign do_pop = pop.valid && pop.ready;
    assign pop.data = mem[rd_ptr];

    always_comb begin
        next_count = count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(do_push);
            rd_ptr <= rd_ptr + AW'(do_pop);
            count <= next_count;
        end
    end

    // Flags registered so the top outputs come from flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            push.ready <= 1'b1;
            pop.valid <= 1'b0;
        end else begin
            push.ready <= next_count != (AW + 1)'(DEPTH);
            pop.valid <= next_count != '0;
        end
    end
endmodule

// >>> universal_shift_register.sv
// Four-stage universal shift register with snapshot stream
`timescale 1ns/1ps
module universal_shift_register
    import shift_register_pkg::*;
#(
    parameter int FIFO_DEPTH = SNAPSHOT_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear_all_n,
    input wire logic load_select_n,
    input wire logic serial_set_in,
    input wire logic serial_clear_n_in,
    input wire logic [STAGE_COUNT-1:0] load_word_in,
    output logic [STAGE_COUNT-1:0] stage_out,
    output logic last_stage_inverted,
    output logic snap_out_valid,
    input wire logic snap_out_ready,
    output logic [STAGE_COUNT-1:0] snap_out_data,
    output logic snap_in_ready,
    output logic snap_dropped
);
    if (STAGE_COUNT != 4 || FIFO_DEPTH < 2) begin : g_param_check
        $error("universal_shift_register needs four stages, depth >= 2");
    end
    // Pointer wrap in the FIFO relies on a power-of-two depth
    if ((FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_pow2_check
        $error("universal_shift_register depth must be a power of two");
    end

    // ------------------------------------------------------------
    // Next-state selection
    // ------------------------------------------------------------
    mode_t mode;
    jk_action_t jk_action;
    logic next_first;
    logic [STAGE_COUNT-1:0] next_stage;

    assign mode = load_select_n ? MODE_SHIFT : MODE_LOAD;
    assign jk_action = jk_action_t'({serial_set_in, serial_clear_n_in});

    always_comb begin
        case (jk_action)
            JK_CLEAR: next_first = 1'b0;
            JK_HOLD: next_first = stage_out[0];
            JK_TOGGLE: next_first = ~stage_out[0];
            default: next_first = 1'b1;
        endcase
    end

    always_comb begin
        case (mode)
            MODE_SHIFT: begin
                next_stage = {stage_out[STAGE_COUNT-2:0], next_first};
            end
            default: begin
                next_stage = load_word_in;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Stage flops
    // ------------------------------------------------------------
    // No rst_n branch: stages stay unknown until cleared or loaded
    always_ff @(posedge clk or negedge clear_all_n) begin
        if (!clear_all_n) begin
            stage_out <= STAGES_CLEARED;
            last_stage_inverted <= ~STAGES_CLEARED[STAGE_COUNT-1];
        end else begin
            stage_out <= next_stage;
            last_stage_inverted <= ~next_stage[STAGE_COUNT-1];
        end
    end

    // ------------------------------------------------------------
    // Snapshot stream
    // ------------------------------------------------------------
    stream_if #(.WIDTH(STAGE_COUNT)) fill_if ();
    stream_if #(.WIDTH(STAGE_COUNT)) drain_if ();

    // Push each new stage word after an edge that changed it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fill_if.valid <= SNAP_IDLE;
            fill_if.data <= STAGES_CLEARED;
        end else begin
            // No snapshot while the clear holds the stages low
            fill_if.valid <= clear_all_n && next_stage != stage_out;
            fill_if.data <= next_stage;
        end
    end

    // Snapshot lost when the FIFO was full
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            snap_dropped <= DROP_NONE;
        end else begin
            snap_dropped <= fill_if.valid && !fill_if.ready;
        end
    end

    snapshot_fifo #(
        .WIDTH(STAGE_COUNT),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .push(fill_if.sink),
        .pop(drain_if.source)
    );

    assign drain_if.ready = snap_out_ready;
    assign snap_out_valid = drain_if.valid;
    assign snap_out_data = drain_if.data;
    assign snap_in_ready = fill_if.ready;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!clear_all_n);

    AST_SHIFT_MOVES: assert property (
        load_select_n |=> stage_out[3:1] == $past(stage_out[2:0]))
        else $error("shift did not move stages up");
    AST_JK_CLEAR: assert property (
        load_select_n && !serial_set_in && !serial_clear_n_in
        |=> !stage_out[0])
        else $error("serial clear failed");
    AST_JK_HOLD: assert property (
        load_select_n && !serial_set_in && serial_clear_n_in
        |=> $stable(stage_out[0]))
        else $error("serial hold failed");
    AST_JK_TOGGLE: assert property (
        load_select_n && serial_set_in && !serial_clear_n_in
        |=> stage_out[0] != $past(stage_out[0]))
        else $error("serial invert failed");
    AST_JK_SET: assert property (
        load_select_n && serial_set_in && serial_clear_n_in
        |=> stage_out[0])
        else $error("serial set failed");
    AST_PARALLEL_LOAD: assert property (
        !load_select_n |=> stage_out == $past(load_word_in))
        else $error("parallel load failed");
    AST_INVERTED_LAST: assert property (
        ##1 last_stage_inverted == ~stage_out[3])
        else $error("inverted output mismatch");
    AST_CLEAR_HOLDS: assert property (
        @(posedge clk) disable iff (1'b0)
        !clear_all_n |-> stage_out == STAGES_CLEARED && last_stage_inverted)
        else $error("clear did not hold stages low");
    AST_SNAPSHOT_KEPT: assert property (
        @(posedge clk) disable iff (!rst_n)
        fill_if.valid && fill_if.ready |=> !snap_dropped)
        else $error("snapshot dropped while room remained");

    // ------------------------------------------------------------
    // Inverted output and snapshot path checks
    // ------------------------------------------------------------
    AST_LOAD_LAST_INV: assert property (
        !load_select_n
        |=> last_stage_inverted == !$past(load_word_in[STAGE_COUNT-1]))
        else $error("inverted output wrong after load");
    AST_SHIFT_LAST_INV: assert property (
        load_select_n
        |=> last_stage_inverted == !$past(stage_out[STAGE_COUNT-2]))
        else $error("inverted output wrong after shift");
    // A changed stage word must sit in the push flop
    AST_SNAP_ON_CHANGE: assert property (
        @(posedge clk) disable iff (!rst_n || !clear_all_n)
        stage_out != $past(stage_out)
        |-> fill_if.valid && fill_if.data == stage_out)
        else $error("changed stage word not offered to the FIFO");
    AST_VALID_AFTER_PUSH: assert property (
        @(posedge clk) disable iff (!rst_n)
        fill_if.valid && fill_if.ready |=> snap_out_valid)
        else $error("pushed snapshot not offered");
    // Consumer stall must not disturb the offered word
    AST_SNAP_HELD: assert property (
        @(posedge clk) disable iff (!rst_n)
        snap_out_valid && !snap_out_ready
        |=> snap_out_valid && $stable(snap_out_data))
        else $error("offered snapshot changed while stalled");
    AST_FULL_NOT_EMPTY: assert property (
        @(posedge clk) disable iff (!rst_n)
        !snap_in_ready |-> snap_out_valid)
        else $error("FIFO full but nothing offered");
    AST_ROOM_AFTER_POP: assert property (
        @(posedge clk) disable iff (!rst_n)
        !snap_in_ready && snap_out_valid && snap_out_ready
        |=> snap_in_ready)
        else $error("FIFO stayed full after a pop");
    AST_DROP_ONLY_FULL: assert property (
        @(posedge clk) disable iff (!rst_n)
        snap_dropped |-> $past(fill_if.valid && !snap_in_ready))
        else $error("snapshot dropped with room left");

    // ------------------------------------------------------------
    // Scenario coverage
    // ------------------------------------------------------------
    COV_SHIFT_RUN: cover property (load_select_n [*4]);
    COV_LOAD_THEN_SHIFT: cover property (!load_select_n ##1 load_select_n);
    COV_TOGGLE: cover property (
        load_select_n && serial_set_in && !serial_clear_n_in);
    COV_FIFO_FULL: cover property (@(posedge clk) !snap_in_ready);
    COV_SNAP_DROPPED: cover property (@(posedge clk) snap_dropped);
endmodule

// >>> surround_model.sv
// Surrounding logic: feedback word source and snapshot consumer
`timescale 1ns/1ps
module surround_model
    import shift_register_pkg::*;
(
    input wire logic clk,
    input wire logic feedback,
    input wire logic stall,
    input wire logic [STAGE_COUNT-1:0] word,
    input wire logic [STAGE_COUNT-1:0] stage,
    input wire logic valid,
    output logic ready,
    output logic [STAGE_COUNT-1:0] load_word,
    output int pops
);
    // Stage n fed back to load bit n-1 gives a shift toward stage 0
    assign load_word = feedback ? {1'b0, stage[3:1]} : word;
    assign ready = !stall;
    initial pops = 0;
    always @(posedge clk) begin
        if (valid && ready) begin
            pops <= pops + 1;
        end
    end
endmodule

// >>> universal_shift_register_tb.sv
// Testbench for the four-stage universal shift register
`timescale 1ns/1ps
module universal_shift_register_tb;
    import shift_register_pkg::*;
    localparam int DEPTH = 4;
    logic clk = 0, rst_n = 0, clear_all_n = 1, load_select_n = 1;
    logic serial_set_in = 0, serial_clear_n_in = 0;
    logic feedback = 0, stall = 0, seen_drop = 0;
    logic [3:0] word = 4'h0, load_word_in, stage_out, snap_out_data, exp_st;
    logic last_stage_inverted, snap_out_valid, snap_out_ready;
    logic snap_in_ready, snap_dropped;
    int pops, p0, n_mismatch = 0, samples_checked = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (snap_dropped === 1'b1) seen_drop <= 1'b1;
    universal_shift_register #(.FIFO_DEPTH(DEPTH)) universal_shift_register_i (
        .clk, .rst_n, .clear_all_n, .load_select_n, .serial_set_in,
        .serial_clear_n_in, .load_word_in, .stage_out, .last_stage_inverted,
        .snap_out_valid, .snap_out_ready, .snap_out_data, .snap_in_ready,
        .snap_dropped);
    surround_model surround_model_i (.clk, .feedback, .stall, .word,
        .stage(stage_out), .valid(snap_out_valid), .ready(snap_out_ready),
        .load_word(load_word_in), .pops);
    task automatic chk(string what, logic [3:0] e, logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    // One edge with given mode and inputs, then judge both outputs
    task automatic cyc(logic ld_n, logic j, logic k, logic [3:0] w);
        logic s0;
        load_select_n = ld_n;
        serial_set_in = j;
        serial_clear_n_in = k;
        word = w;
        s0 = j ? (k ? 1'b1 : ~exp_st[0]) : (k ? exp_st[0] : 1'b0);
        if (!ld_n) exp_st = feedback ? {1'b0, exp_st[3:1]} : w;
        else exp_st = {exp_st[2:0], s0};
        @(posedge clk);
        #2;
        chk("stage_out", exp_st, stage_out);
        chk("inverted", {3'h0, ~exp_st[3]}, {3'h0, last_stage_inverted});
    endtask
    task automatic t_load;
        cyc(0, 1, 0, 4'hA);
        cyc(0, 0, 0, 4'h5);
        cyc(0, 1, 1, 4'h0);
        cyc(0, 0, 1, 4'hF);
    endtask
    task automatic t_jk;
        for (int i = 0; i < 8; i++) begin
            cyc(1, i[1], i[0], 4'h0);
        end
        cyc(1, 1, 1, 4'h0);
        cyc(1, 0, 0, 4'hF);
    endtask
    task automatic t_left;
        cyc(0, 0, 0, 4'hF);
        feedback = 1;
        repeat (4) cyc(0, 0, 0, 4'h0);
        feedback = 0;
    endtask
    task automatic t_between;
        load_select_n = 0;
        word = ~exp_st;
        serial_set_in = 1;
        #10;
        chk("stage_out", exp_st, stage_out);
        exp_st = ~exp_st;
        @(posedge clk);
        #2;
        chk("stage_out", exp_st, stage_out);
        cyc(1, 0, 1, 4'h0);
    endtask
    task automatic t_clear;
        cyc(0, 0, 0, 4'hA);
        word = 4'hF;
        clear_all_n = 0;
        #3;
        chk("stage_out", 4'h0, stage_out);
        @(posedge clk);
        #2;
        chk("stage_out", 4'h0, stage_out);
        chk("inverted", 4'h1, {3'h0, last_stage_inverted});
        clear_all_n = 1;
        exp_st = 4'h0;
        cyc(0, 0, 0, 4'h9);
    endtask
    task automatic t_fifo;
        logic [3:0] snaps [DEPTH];
        repeat (8) @(posedge clk);
        #2;
        chk("dropped", 4'h0, {3'h0, seen_drop});
        p0 = pops;
        stall = 1;
        for (int i = 0; i < 8; i++) begin
            cyc(1, 1, 0, 4'h0);
            if (i < DEPTH) snaps[i] = exp_st;
        end
        load_select_n = 0;
        word = exp_st;
        repeat (3) @(posedge clk);
        #2;
        chk("in_ready", 4'h0, {3'h0, snap_in_ready});
        chk("dropped", 4'h1, {3'h0, seen_drop});
        stall = 0;
        for (int i = 0; i < DEPTH; i++) begin
            chk("snap_data", snaps[i], snap_out_data);
            @(posedge clk);
            #2;
        end
        repeat (4) @(posedge clk);
        #2;
        chk("pops", DEPTH[3:0], 4'(pops - p0));
        chk("out_valid", 4'h0, {3'h0, snap_out_valid});
    endtask
    task automatic complete_run;
        $display("Counts: %0d mismatches, %0d checked", n_mismatch,
            samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #50000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        #2;
        clear_all_n = 0;
        repeat (20) @(posedge clk);
        #2;
        rst_n = 1;
        clear_all_n = 1;
        exp_st = 4'h0;
        t_load();
        t_jk();
        t_left();
        t_between();
        t_clear();
        t_fifo();
        complete_run();
    end
endmodule
